// file: hw/sys_cfg_pkg.sv
// Purpose: Constants for the reset-mode configuration and system configuration block
// Assumes: 24-bit address space, 4-bit arbitration IDs
// Notes: Strap line positions follow the data bus bit numbers
package sys_cfg_pkg;
	localparam int ADDR_W = 24;
	localparam int ARB_W = 4;
	localparam int NUM_CS = 12;
	localparam int NUM_SRC = 4;
	// Strap line positions on the data bus
	localparam int STRAP_BOOT8 = 0;
	localparam int STRAP_ARB = 1;
	localparam int STRAP_FC = 2;
	localparam int STRAP_ADDR_LO = 3;
	localparam int STRAP_ADDR_HI = 7;
	localparam int STRAP_BUS_CONTROL_GPIO = 8;
	localparam int STRAP_IRQ_GPIO = 9;
	localparam int STRAP_TEST = 11;
	// Register block placement
	localparam logic [11:0] REG_BLOCK_TOP = 12'hfff;
	localparam logic [ADDR_W-1:0] REG_BASE_LOW = 24'h7ff000;
	localparam logic [ADDR_W-1:0] REG_BASE_HIGH = 24'hfff000;
	// Reset values
	localparam logic [ARB_W-1:0] ARB_ID_OWN_RST = 4'hf;
	localparam logic [ARB_W-1:0] ARB_ID_OTHER_RST = 4'h0;
	localparam logic [1:0] SHOW_RST = 2'h0;
	localparam logic MM_RST = 1'b1;
	localparam logic SUPERVISOR_ONLY_BIT_RST = 1'b1;
	// Show-cycle field encodings
	localparam logic [1:0] SHOW_OFF = 2'h0;
	localparam logic [1:0] SHOW_NOARB = 2'h1;
	localparam logic [1:0] SHOW_ARB = 2'h2;
	localparam logic [1:0] SHOW_HALT = 2'h3;
endpackage

// file: hw/arb_contender.sv
// Purpose: One participant in bitwise serial contention of arbitration IDs
// Assumes: Wired-OR contention line built by the caller, MSB first
// Notes: A zero ID never wins
`default_nettype none
module arb_contender #(
	parameter int W = 4
) (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic step_i,
	input wire logic [1:0] bit_idx_i,
	input wire logic req_i,
	input wire logic [W-1:0] id_i,
	input wire logic line_i,
	output logic drive_o,
	output logic alive_o
);
	logic alive_q;
	assign drive_o = alive_q & id_i[bit_idx_i];
	assign alive_o = alive_q;
	always_ff @(posedge clk_i) begin
		if (start_i) begin
			alive_q <= req_i & (id_i != '0);
		end else if (step_i && line_i && !id_i[bit_idx_i]) begin
			alive_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: hw/sys_cfg.sv
// Purpose: Reset strap capture, pin function select, register map base, arbitration
// Assumes: Strap pins come from outside the clock domain
// Notes: Configuration fields arrive as plain ports
`default_nettype none
module sys_cfg #(
	parameter int NUM_SRC = sys_cfg_pkg::NUM_SRC
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Reset straps
	input wire logic [15:0] DATA_STRAP_I,
	input wire logic CLOCK_SOURCE_SELECT_PIN_I,
	input wire logic BREAKPOINT_PIN_I,
	// Configuration fields
	input wire logic MODULE_MAP_BIT_I,
	input wire logic [1:0] SHOW_CYCLE_FIELD_I,
	input wire logic SUPERVISOR_ONLY_BIT_I,
	input wire logic [sys_cfg_pkg::ARB_W-1:0] OWN_ARB_ID_I,
	input wire logic [NUM_SRC*sys_cfg_pkg::ARB_W-1:0] SRC_ARB_ID_I,
	input wire logic OWN_ARB_ID_WE_I,
	input wire logic [NUM_SRC-1:0] SRC_ARB_ID_WE_I,
	// Internal bus access check
	input wire logic ACCESS_VALID_I,
	input wire logic ACCESS_USER_I,
	input wire logic ACCESS_CONTROLLED_I,
	input wire logic [sys_cfg_pkg::ADDR_W-1:0] ACCESS_ADDR_I,
	input wire logic [sys_cfg_pkg::ADDR_W-1:0] INT_XFER_ADDR_I,
	input wire logic INT_XFER_VALID_I,
	// Interrupt acknowledge
	input wire logic IACK_I,
	input wire logic EXT_IRQ_I,
	input wire logic [NUM_SRC-1:0] SRC_IRQ_I,
	input wire logic BUS_GRANTED_I,
	// Strap results
	output logic BOOT_CHIP_SELECT_8BIT_O,
	output logic ARB_PINS_EN_O,
	output logic FUNCTION_CODE_PINS_EN_O,
	output logic [4:0] ADDR_HI_PIN_EN_O,
	output logic BUS_CONTROL_GPIO_EN_O,
	output logic IRQ_GPIO_EN_O,
	output logic CLK_FROM_CRYSTAL_O,
	output logic BACKGROUND_EN_O,
	output logic TEST_SLAVE_STATUS_BIT_O,
	output logic PORTS_INPUT_O,
	output logic [sys_cfg_pkg::NUM_CS-1:0] CS_PIN_EN_O,
	// Bus control
	output logic REG_HIT_O,
	output logic ACCESS_REFUSED_O,
	output logic SHOW_DRIVE_O,
	output logic [sys_cfg_pkg::ADDR_W-1:0] SHOW_ADDR_O,
	output logic EXT_ARB_EN_O,
	output logic INTERNAL_HALT_O,
	// Arbitration result
	output logic ARB_DONE_O,
	output logic ARB_SPURIOUS_O,
	output logic [NUM_SRC:0] ARB_WINNER_O,
	output logic [sys_cfg_pkg::ARB_W-1:0] OWN_ARB_ID_O
);
	import sys_cfg_pkg::*;

	typedef enum {ARB_IDLE, ARB_RUN, ARB_END} arb_state_t;

	logic [15:0] strap_meta_q, strap_sync_q;
	logic [1:0] clk_meta_q, clk_sync_q;
	logic [4:0] addr_hi_d;
	logic show_on, ext_arb_on, halt_on_grant;
	logic [ARB_W-1:0] own_id_q;
	logic [ARB_W-1:0] src_id_q [NUM_SRC];
	arb_state_t arb_q;
	logic [1:0] bit_q;
	logic [NUM_SRC:0] drive, alive, reqs;
	logic line;
	logic arb_start, arb_step;

	// Strap synchronisers
	always_ff @(posedge CLK_I) begin
		strap_meta_q <= DATA_STRAP_I;
		strap_sync_q <= strap_meta_q;
		clk_meta_q <= {CLOCK_SOURCE_SELECT_PIN_I, BREAKPOINT_PIN_I};
		clk_sync_q <= clk_meta_q;
	end

	// Address strap decode: a low line also swaps every lower address bit
	always_comb begin
		addr_hi_d = '0;
		for (int i = 0; i < 5; i++) begin
			for (int j = 0; j < 5; j++) begin
				if (j >= i && !strap_sync_q[STRAP_ADDR_LO + j]) begin
					addr_hi_d[i] = 1'b1;
				end
			end
		end
	end

	// Boot port and pin function straps, frozen after release
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			BOOT_CHIP_SELECT_8BIT_O <= !strap_sync_q[STRAP_BOOT8];
			ARB_PINS_EN_O <= !strap_sync_q[STRAP_ARB];
			FUNCTION_CODE_PINS_EN_O <= !strap_sync_q[STRAP_FC];
			ADDR_HI_PIN_EN_O <= addr_hi_d;
		end
	end

	// Bus control and interrupt pins as general-purpose ports
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			BUS_CONTROL_GPIO_EN_O <= !strap_sync_q[STRAP_BUS_CONTROL_GPIO];
			IRQ_GPIO_EN_O <= !strap_sync_q[STRAP_IRQ_GPIO];
		end
	end

	// Clock source and background debug straps
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			CLK_FROM_CRYSTAL_O <= !clk_sync_q[1];
			BACKGROUND_EN_O <= !clk_sync_q[0];
		end
	end

	// Factory test slave status
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			TEST_SLAVE_STATUS_BIT_O <= !strap_sync_q[STRAP_TEST];
		end
	end

	// Other module pins leave reset as input ports
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			PORTS_INPUT_O <= 1'b1;
		end
	end

	// Chip-select pin enables follow strap results
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			CS_PIN_EN_O <= '1;
		end else begin
			CS_PIN_EN_O[0] <= 1'b1;
			CS_PIN_EN_O[3:1] <= {3{!ARB_PINS_EN_O}};
			CS_PIN_EN_O[6:4] <= {3{!FUNCTION_CODE_PINS_EN_O}};
			CS_PIN_EN_O[11:7] <= ~ADDR_HI_PIN_EN_O;
		end
	end

	// Register block decode and privilege check
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			REG_HIT_O <= 1'b0;
			ACCESS_REFUSED_O <= 1'b0;
		end else begin
			REG_HIT_O <= ACCESS_VALID_I && (ACCESS_ADDR_I[ADDR_W-1:12] ==
				(MODULE_MAP_BIT_I ? REG_BASE_HIGH[ADDR_W-1:12] : REG_BASE_LOW[ADDR_W-1:12]));
			ACCESS_REFUSED_O <= ACCESS_VALID_I && ACCESS_CONTROLLED_I && ACCESS_USER_I &&
				SUPERVISOR_ONLY_BIT_I;
		end
	end

	// Show-cycle field decode
	always_comb begin
		show_on = 1'b1;
		ext_arb_on = 1'b1;
		halt_on_grant = 1'b0;
		case (SHOW_CYCLE_FIELD_I)
			SHOW_OFF: begin
				show_on = 1'b0;
			end
			SHOW_NOARB: begin
				ext_arb_on = 1'b0;
			end
			SHOW_ARB: begin
				halt_on_grant = 1'b0;
			end
			SHOW_HALT: begin
				halt_on_grant = 1'b1;
			end
			default: begin
				halt_on_grant = 1'b0;
			end
		endcase
	end

	// Show cycles and external arbitration
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			SHOW_DRIVE_O <= 1'b0;
			SHOW_ADDR_O <= '0;
			EXT_ARB_EN_O <= 1'b1;
			INTERNAL_HALT_O <= 1'b0;
		end else begin
			SHOW_DRIVE_O <= INT_XFER_VALID_I && show_on;
			if (INT_XFER_VALID_I && show_on) begin
				SHOW_ADDR_O <= INT_XFER_ADDR_I;
			end
			EXT_ARB_EN_O <= ext_arb_on;
			INTERNAL_HALT_O <= halt_on_grant && BUS_GRANTED_I;
		end
	end

	// Arbitration IDs
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			own_id_q <= ARB_ID_OWN_RST;
			for (int i = 0; i < NUM_SRC; i++) begin
				src_id_q[i] <= ARB_ID_OTHER_RST;
			end
		end else begin
			if (OWN_ARB_ID_WE_I) begin
				own_id_q <= OWN_ARB_ID_I;
			end
			for (int i = 0; i < NUM_SRC; i++) begin
				if (SRC_ARB_ID_WE_I[i]) begin
					src_id_q[i] <= SRC_ARB_ID_I[i*ARB_W +: ARB_W];
				end
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			OWN_ARB_ID_O <= ARB_ID_OWN_RST;
		end else begin
			OWN_ARB_ID_O <= own_id_q;
		end
	end

	// Serial contention: slot 0 is this module carrying external requests
	assign reqs = {SRC_IRQ_I, EXT_IRQ_I};
	assign arb_start = (arb_q == ARB_IDLE) && IACK_I;
	assign arb_step = (arb_q == ARB_RUN);
	assign line = |drive;

	arb_contender #(.W(ARB_W)) own_u (
		.clk_i(CLK_I),
		.start_i(arb_start),
		.step_i(arb_step),
		.bit_idx_i(bit_q),
		.req_i(reqs[0]),
		.id_i(own_id_q),
		.line_i(line),
		.drive_o(drive[0]),
		.alive_o(alive[0])
	);

	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		arb_contender #(.W(ARB_W)) src_u (
			.clk_i(CLK_I),
			.start_i(arb_start),
			.step_i(arb_step),
			.bit_idx_i(bit_q),
			.req_i(reqs[g+1]),
			.id_i(src_id_q[g]),
			.line_i(line),
			.drive_o(drive[g+1]),
			.alive_o(alive[g+1])
		);
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			arb_q <= ARB_IDLE;
			bit_q <= 2'h3;
			ARB_DONE_O <= 1'b0;
			ARB_SPURIOUS_O <= 1'b0;
			ARB_WINNER_O <= '0;
		end else begin
			ARB_DONE_O <= 1'b0;
			case (arb_q)
				ARB_IDLE: begin
					if (arb_start) begin
						arb_q <= ARB_RUN;
						bit_q <= 2'h3;
					end
				end
				ARB_RUN: begin
					if (bit_q == 2'h0) begin
						arb_q <= ARB_END;
					end else begin
						bit_q <= bit_q - 2'h1;
					end
				end
				ARB_END: begin
					ARB_DONE_O <= 1'b1;
					ARB_WINNER_O <= alive;
					ARB_SPURIOUS_O <= (alive == '0);
					arb_q <= ARB_IDLE;
				end
				default: arb_q <= ARB_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: sim/sys_cfg_monitor.sv
// Purpose: Port checker for sys_cfg
// Assumes: One clock, sync active-low reset
// Notes: Bound into every sys_cfg instance
`default_nettype none
module sys_cfg_monitor import sys_cfg_pkg::*; #(parameter int NUM_SRC = 4) (
	// Clock, reset and requests
	input wire logic CLK_I, RESETN_I, IACK_I, BUS_GRANTED_I, INT_XFER_VALID_I,
	input wire logic ACCESS_VALID_I, ACCESS_USER_I, ACCESS_CONTROLLED_I, MODULE_MAP_BIT_I,
	input wire logic SUPERVISOR_ONLY_BIT_I,
	input wire logic [1:0] SHOW_CYCLE_FIELD_I,
	input wire logic [ADDR_W-1:0] ACCESS_ADDR_I, INT_XFER_ADDR_I,
	// Results
	input wire logic REG_HIT_O, ACCESS_REFUSED_O, SHOW_DRIVE_O, EXT_ARB_EN_O, INTERNAL_HALT_O,
	input wire logic ARB_DONE_O, ARB_SPURIOUS_O, PORTS_INPUT_O, ARB_PINS_EN_O,
	input wire logic FUNCTION_CODE_PINS_EN_O, BOOT_CHIP_SELECT_8BIT_O,
	input wire logic [4:0] ADDR_HI_PIN_EN_O,
	input wire logic [NUM_CS-1:0] CS_PIN_EN_O,
	input wire logic [ADDR_W-1:0] SHOW_ADDR_O,
	input wire logic [ARB_W-1:0] OWN_ARB_ID_O,
	input wire logic [NUM_SRC:0] ARB_WINNER_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [2:0] cnt_q;
	logic hit;
	logic ref_c;
	assign hit = (ACCESS_ADDR_I[23:12] == {MODULE_MAP_BIT_I, 11'h7ff});
	assign ref_c = ACCESS_USER_I & ACCESS_CONTROLLED_I & SUPERVISOR_ONLY_BIT_I;
	// Contention run tracker
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) cnt_q <= 3'h0;
		else if (IACK_I && cnt_q == 3'h0) cnt_q <= 3'h6;
		else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
	end
	a_map_hit: assert property (ACCESS_VALID_I |=> REG_HIT_O == $past(hit))
		else $error("register hit wrong");
	a_user_refused: assert property (
		ACCESS_VALID_I && hit |=> ACCESS_REFUSED_O == $past(ref_c)) else $error("refusal wrong");
	a_show_off: assert property (
		INT_XFER_VALID_I |=> SHOW_DRIVE_O == ($past(SHOW_CYCLE_FIELD_I) != SHOW_OFF))
		else $error("show drive wrong");
	a_show_addr: assert property (
		INT_XFER_VALID_I && SHOW_CYCLE_FIELD_I != SHOW_OFF |=> SHOW_ADDR_O == $past(INT_XFER_ADDR_I))
		else $error("show address wrong");
	a_arb_enable: assert property (
		$past(RESETN_I) |-> EXT_ARB_EN_O == ($past(SHOW_CYCLE_FIELD_I) != SHOW_NOARB))
		else $error("arbitration enable wrong");
	a_grant_halt: assert property (
		$past(RESETN_I) |-> INTERNAL_HALT_O ==
		($past(SHOW_CYCLE_FIELD_I) == SHOW_HALT && $past(BUS_GRANTED_I))) else $error("halt wrong");
	a_arb_timing: assert property (
		IACK_I && cnt_q == 3'h0 |=> !ARB_DONE_O [*5] ##1 ARB_DONE_O) else $error("done timing");
	a_zero_spurious: assert property (
		ARB_DONE_O |-> ARB_SPURIOUS_O == (ARB_WINNER_O == '0) && $onehot0(ARB_WINNER_O))
		else $error("spurious wrong");
	a_own_id_rst: assert property ($rose(RESETN_I) |-> OWN_ARB_ID_O == ARB_ID_OWN_RST)
		else $error("own id reset");
	a_straps_held: assert property (
		$past(RESETN_I) |-> $stable({ADDR_HI_PIN_EN_O, ARB_PINS_EN_O, FUNCTION_CODE_PINS_EN_O,
		BOOT_CHIP_SELECT_8BIT_O})) else $error("strap moved");
	a_cs_share: assert property (
		$past(RESETN_I, 2) |-> CS_PIN_EN_O == {~ADDR_HI_PIN_EN_O, {3{~FUNCTION_CODE_PINS_EN_O}},
		{3{~ARB_PINS_EN_O}}, 1'b1}) else $error("chip select share");
	a_ports_input: assert property (PORTS_INPUT_O) else $error("ports not input");
endmodule
bind sys_cfg sys_cfg_monitor #(.NUM_SRC(NUM_SRC)) mon (.*);
`default_nettype wire

// file: sim/sys_cfg_strap_drv.sv
// Purpose: External party on the strap lines
// Assumes: Straps held through reset
// Notes: After release the lines toggle to prove latching
`default_nettype none
module sys_cfg_strap_drv (
	input wire logic clk_i, resetn_i,
	input wire logic [17:0] cfg_i,
	output logic [15:0] data_o,
	output logic clk_sel_o, breakpoint_pin_o
);
	logic [17:0] tog_q;
	always_ff @(posedge clk_i) begin
		if (!resetn_i) tog_q <= ~cfg_i;
		else tog_q <= ~tog_q;
	end
	assign {breakpoint_pin_o, clk_sel_o, data_o} = resetn_i ? tog_q : cfg_i;
endmodule
`default_nettype wire

// file: sim/sys_cfg_tb_top.sv
// Purpose: Self-checking bench for sys_cfg
// Assumes: Seeded random stimulus with corner straps
// Notes: Expected values from bench functions
`default_nettype none
module sys_cfg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_I, RESETN_I, CLOCK_SOURCE_SELECT_PIN_I, BREAKPOINT_PIN_I, MODULE_MAP_BIT_I;
	logic SUPERVISOR_ONLY_BIT_I, OWN_ARB_ID_WE_I, ACCESS_VALID_I, ACCESS_USER_I;
	logic ACCESS_CONTROLLED_I, INT_XFER_VALID_I, IACK_I, EXT_IRQ_I, BUS_GRANTED_I;
	logic BOOT_CHIP_SELECT_8BIT_O, ARB_PINS_EN_O, FUNCTION_CODE_PINS_EN_O, BUS_CONTROL_GPIO_EN_O;
	logic IRQ_GPIO_EN_O, CLK_FROM_CRYSTAL_O, BACKGROUND_EN_O, TEST_SLAVE_STATUS_BIT_O;
	logic PORTS_INPUT_O, REG_HIT_O, ACCESS_REFUSED_O, SHOW_DRIVE_O, EXT_ARB_EN_O;
	logic INTERNAL_HALT_O, ARB_DONE_O, ARB_SPURIOUS_O;
	logic [1:0] SHOW_CYCLE_FIELD_I;
	logic [3:0] OWN_ARB_ID_I, SRC_ARB_ID_WE_I, SRC_IRQ_I, OWN_ARB_ID_O, o;
	logic [4:0] ADDR_HI_PIN_EN_O, ARB_WINNER_O;
	logic [11:0] CS_PIN_EN_O;
	logic [15:0] DATA_STRAP_I, SRC_ARB_ID_I, t;
	logic [23:0] ACCESS_ADDR_I, INT_XFER_ADDR_I, SHOW_ADDR_O, a;
	logic [17:0] cfg;
	logic [31:0] r;
	logic h;
	int seed = 29;
	int miscompares = 0;
	int num_checks = 0;
	sys_cfg dut (.*);
	sys_cfg_strap_drv far (.clk_i(CLK_I), .resetn_i(RESETN_I), .cfg_i(cfg),
		.data_o(DATA_STRAP_I), .clk_sel_o(CLOCK_SOURCE_SELECT_PIN_I), .breakpoint_pin_o(BREAKPOINT_PIN_I));
	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic [13:0] exp_st(input logic [17:0] c);
		logic [4:0] e;
		e = '0;
		for (int i = 0; i < 5; i++) for (int j = i; j < 5; j++) if (!c[3+j]) e[i] = 1'b1;
		return {~c[17], ~c[16], ~c[11], ~c[9], ~c[8], e, ~c[2], ~c[1], ~c[0], 1'b1};
	endfunction
	task automatic rst(input logic [17:0] c);
		logic [13:0] x;
		x = exp_st(c);
		@(posedge CLK_I);
		cfg <= c;
		RESETN_I <= 1'b0;
		repeat (8) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		@(negedge CLK_I);
		chk({BACKGROUND_EN_O, CLK_FROM_CRYSTAL_O, TEST_SLAVE_STATUS_BIT_O, IRQ_GPIO_EN_O,
			BUS_CONTROL_GPIO_EN_O, ADDR_HI_PIN_EN_O, FUNCTION_CODE_PINS_EN_O, ARB_PINS_EN_O,
			BOOT_CHIP_SELECT_8BIT_O, PORTS_INPUT_O}, x);
		chk(CS_PIN_EN_O, {~x[8:4], {3{~x[3]}}, {3{~x[2]}}, 1'b1});
		chk(OWN_ARB_ID_O, 4'hf);
	endtask
	task automatic arb(input logic [3:0] rq, input logic e, input logic [3:0] ow,
		input logic [15:0] s);
		logic [4:0] w;
		logic [3:0] best;
		w = '0;
		best = '0;
		if (e && ow != 4'h0) {w, best} = {5'h1, ow};
		for (int i = 0; i < 4; i++) if (rq[i] && s[4*i+:4] > best) {w, best} = {5'h2 << i, s[4*i+:4]};
		SRC_IRQ_I <= rq;
		EXT_IRQ_I <= e;
		IACK_I <= 1'b1;
		@(posedge CLK_I);
		IACK_I <= 1'b0;
		repeat (5) @(posedge CLK_I);
		@(negedge CLK_I);
		chk(ARB_DONE_O, 1'b1);
		chk(ARB_WINNER_O, w);
		chk(ARB_SPURIOUS_O, w == 5'h0);
		chk(OWN_ARB_ID_O, ow);
		@(posedge CLK_I);
	endtask
	initial begin
		#50us;
		miscompares++;
		test_done();
	end
	initial begin
		{RESETN_I, MODULE_MAP_BIT_I, SUPERVISOR_ONLY_BIT_I, ACCESS_VALID_I, ACCESS_USER_I} = '0;
		{ACCESS_CONTROLLED_I, INT_XFER_VALID_I, IACK_I, EXT_IRQ_I, BUS_GRANTED_I} = '0;
		{OWN_ARB_ID_WE_I, SHOW_CYCLE_FIELD_I, OWN_ARB_ID_I, SRC_ARB_ID_WE_I, SRC_IRQ_I} = '0;
		{SRC_ARB_ID_I, ACCESS_ADDR_I, INT_XFER_ADDR_I} = '0;
		cfg = '1;
		for (int k = 0; k < 12; k++) begin
			r = $random(seed);
			rst(k == 0 ? '1 : k < 6 ? ~(18'h4 << k) : k == 6 ? '0 : r[17:0]);
		end
		@(posedge CLK_I);
		arb(4'hf, 1'b0, 4'hf, 16'h0);
		repeat (60) begin
			r = $random(seed);
			@(posedge CLK_I);
			a = {r[1] ? {r[2], 11'h7ff} : r[23:12], r[11:0]};
			h = (a[23:12] == {r[3], 11'h7ff});
			{ACCESS_ADDR_I, MODULE_MAP_BIT_I, ACCESS_USER_I} <= {a, r[3], r[4]};
			{ACCESS_CONTROLLED_I, SUPERVISOR_ONLY_BIT_I, ACCESS_VALID_I} <= {r[5] & h, r[6], 1'b1};
			{SHOW_CYCLE_FIELD_I, INT_XFER_ADDR_I, BUS_GRANTED_I} <= {r[8:7], r[31:8], r[9]};
			INT_XFER_VALID_I <= 1'b1;
			@(posedge CLK_I);
			{ACCESS_VALID_I, INT_XFER_VALID_I} <= 2'h0;
			@(negedge CLK_I);
			chk(REG_HIT_O, h);
			chk(ACCESS_REFUSED_O, r[4] & r[5] & r[6] & h);
			chk(SHOW_DRIVE_O, r[8:7] != 2'h0);
			if (r[8:7] != 2'h0) chk(SHOW_ADDR_O, r[31:8]);
			chk(EXT_ARB_EN_O, r[8:7] != 2'h1);
			chk(INTERNAL_HALT_O, r[8:7] == 2'h3 && r[9]);
		end
		repeat (20) begin
			r = $random(seed);
			@(posedge CLK_I);
			t = {r[3:0] + 4'h9, r[3:0] + 4'h6, r[3:0] + 4'h3, r[3:0]};
			o = r[3:0] + 4'hc;
			{SRC_ARB_ID_I, OWN_ARB_ID_I, SRC_ARB_ID_WE_I, OWN_ARB_ID_WE_I} <= {t, o, 4'hf, 1'b1};
			@(posedge CLK_I);
			{SRC_ARB_ID_WE_I, OWN_ARB_ID_WE_I} <= 5'h0;
			arb(r[7:4], r[8], o, t);
		end
		test_done();
	end
endmodule
`default_nettype wire
